// ---- verilog/brake_slip_pkg.sv ----
package brake_slip_pkg;

   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int PRESC_W = 16;

   localparam int CLK_HZ = 50_000_000;
   localparam int MS_PER_SEC = 1000;
   localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_SEC;

   localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_DLY_ON_REL = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_DLY_REL_RDY = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_DLY_STOP_ENG = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_DLY_ENG_OFF = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_THRESHOLD = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_FB_SCALE = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h7;
   localparam logic [ADDR_W-1:0] ADDR_MASK = 4'h8;
   localparam logic [ADDR_W-1:0] ADDR_STATE = 4'h9;
   localparam logic [ADDR_W-1:0] ADDR_DEVIATION = 4'ha;

   localparam int DLY_ON_REL = 0;
   localparam int DLY_REL_RDY = 1;
   localparam int DLY_STOP_ENG = 2;
   localparam int DLY_ENG_OFF = 3;
   localparam int DLY_N = 4;

   localparam int CTRL_ALARM_CLR = 7;
   localparam logic [DATA_W-1:0] CTRL_WMASK = 16'h007f;
   localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0002;
   localparam logic [DATA_W-1:0] DELAY_RESET = 16'h0000;
   localparam logic [7:0] THRESH_RESET = 8'h00;
   localparam logic [DATA_W-1:0] SCALE_RESET = 16'h0001;

   localparam int EV_SLIP = 0;
   localparam int EV_READY = 1;
   localparam int EV_ENGAGE = 2;
   localparam int EV_ALARM = 3;
   localparam int EV_W = 4;

   typedef enum logic [1:0] {
      ACT_ALARM = 2'b00,
      ACT_CORRECT = 2'b01,
      ACT_IGNORE = 2'b10
   } err_action_e;

   typedef enum logic [2:0] {
      ST_PWR_OFF = 3'b000,
      ST_ON_WAIT = 3'b001,
      ST_REL_WAIT = 3'b010,
      ST_READY = 3'b011,
      ST_STOP_WAIT = 3'b100,
      ST_ENG_WAIT = 3'b101,
      ST_HOLD = 3'b110
   } brake_state_e;

   typedef struct packed {
      logic [8:0] spare;
      logic revInvert;
      err_action_e action;
      logic srcRev;
      logic posEn;
      logic pwrOffEn;
      logic brakeEn;
   } ctrl_s;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      ctrl_s ctrl;
      logic [DLY_N-1:0][DATA_W-1:0] delay;
      logic [7:0] threshold;
      logic [DATA_W-1:0] scale;
      logic [EV_W-1:0] status;
      logic [EV_W-1:0] mask;
      brake_state_e fsm;
      logic [DATA_W-1:0] msLeft;
      logic [PRESC_W-1:0] presc;
      logic motorPower;
      logic brakeEngaged;
      logic readyInt;
      logic motionReady;
      logic alarm;
      logic slipLatched;
      logic irq;
      logic signed [DATA_W-1:0] deviation;
      logic correctValid;
      logic [DATA_W-1:0] correctSteps;
      logic [DATA_W-1:0] rdata;
      logic [2:0] encSync;
      logic [2:0] dirSync;
      logic [2:0] revSync;
   } sv_state_s;

endpackage

// ---- verilog/brake_slip_monitor.sv ----
// Contract
// - brake delays only when brake control enabled
// - power on, wait delay, then release brake
// - after release wait delay before motion ready
// - after motor stop wait delay, engage brake
// - after engage wait delay, then power off
// - each delay is 16-bit unsigned milliseconds
// - power-off option cuts power, else stays on
// - slip monitoring only while position control enabled
// - feedback source: encoder or revolution sensor
// - 8-bit missed-step threshold, 0 to 255
// - missed steps above threshold set slip flag
// - alarm action puts controller into alarm
// - correct action recovers the lost steps
// - ignore action only flags the error
// - revolution sensor active low unless inverted
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module brake_slip_monitor #(
   parameter int MS_CYCLES = brake_slip_pkg::MS_CYCLES_DEF
) (
   input wire logic ref_clk, // system clock
   input wire logic reset, // synchronous, active high
   input wire brake_slip_pkg::reg_req_s regReq, // register request
   input wire logic motionRequest, // motion wanted, level
   input wire logic motorStopped, // motor at rest, level
   input wire logic stepPulse, // one commanded step
   input wire logic stepDir, // commanded direction, 1 = forward
   input wire logic encPulse, // encoder count pin
   input wire logic encDir, // encoder direction pin
   input wire logic revSensor, // revolution sensor pin
   output logic [brake_slip_pkg::DATA_W-1:0] regRdata, // read data
   output logic motorPower, // motor supply on
   output logic brakeEngaged, // brake holding
   output logic motionReady, // motion commands allowed
   output logic alarm, // controller in alarm
   output logic correctValid, // correction request pulse
   output logic [brake_slip_pkg::DATA_W-1:0] correctSteps, // signed
   output logic irq // interrupt, level
);

   localparam logic [brake_slip_pkg::PRESC_W-1:0] PRESC_LAST =
      brake_slip_pkg::PRESC_W'(MS_CYCLES - 1);

   brake_slip_pkg::sv_state_s s;
   brake_slip_pkg::sv_state_s next_s;

   logic timerDone;
   logic encEdge;
   logic revActNow;
   logic revActPrev;
   logic revEvent;
   logic fbEvent;
   logic fbDir;
   logic over;
   logic signed [brake_slip_pkg::DATA_W-1:0] stepDelta;
   logic signed [brake_slip_pkg::DATA_W-1:0] fbDelta;
   logic [brake_slip_pkg::EV_W-1:0] events;
   logic [brake_slip_pkg::EV_W-1:0] kept;

   function automatic logic [brake_slip_pkg::DATA_W-1:0] absVal(
      input logic signed [brake_slip_pkg::DATA_W-1:0] v
   );
      absVal = v[brake_slip_pkg::DATA_W-1] ? brake_slip_pkg::DATA_W'(-v) : v;
   endfunction

   // with brake control off every wait collapses to zero
   function automatic logic [brake_slip_pkg::DATA_W-1:0] delayFor(
      input logic en,
      input logic [brake_slip_pkg::DATA_W-1:0] v
   );
      delayFor = en ? v : brake_slip_pkg::DELAY_RESET;
   endfunction

   function automatic brake_slip_pkg::sv_state_s resetState();
      brake_slip_pkg::sv_state_s r;
      r = '0;
      r.ctrl = brake_slip_pkg::ctrl_s'(brake_slip_pkg::CTRL_RESET);
      r.threshold = brake_slip_pkg::THRESH_RESET;
      r.scale = brake_slip_pkg::SCALE_RESET;
      r.fsm = brake_slip_pkg::ST_PWR_OFF;
      r.brakeEngaged = 1'b1;
      r.readyInt = 1'b0;
      r.motionReady = 1'b0;
      return r;
   endfunction

   always_comb begin
      next_s = s;
      events = '0;
      kept = '0;
      next_s.correctValid = 1'b0;
      next_s.rdata = '0;

      // register writes
      if (regReq.wr) begin
         case (regReq.addr)
            brake_slip_pkg::ADDR_CTRL: begin
               next_s.ctrl = brake_slip_pkg::ctrl_s'(
                  regReq.wdata & brake_slip_pkg::CTRL_WMASK);
               if (regReq.wdata[brake_slip_pkg::CTRL_ALARM_CLR]) begin
                  next_s.alarm = 1'b0;
               end
            end
            brake_slip_pkg::ADDR_DLY_ON_REL: begin
               next_s.delay[brake_slip_pkg::DLY_ON_REL] = regReq.wdata;
            end
            brake_slip_pkg::ADDR_DLY_REL_RDY: begin
               next_s.delay[brake_slip_pkg::DLY_REL_RDY] = regReq.wdata;
            end
            brake_slip_pkg::ADDR_DLY_STOP_ENG: begin
               next_s.delay[brake_slip_pkg::DLY_STOP_ENG] = regReq.wdata;
            end
            brake_slip_pkg::ADDR_DLY_ENG_OFF: begin
               next_s.delay[brake_slip_pkg::DLY_ENG_OFF] = regReq.wdata;
            end
            brake_slip_pkg::ADDR_THRESHOLD: begin
               next_s.threshold = regReq.wdata[7:0];
            end
            brake_slip_pkg::ADDR_FB_SCALE: begin
               next_s.scale = regReq.wdata;
            end
            brake_slip_pkg::ADDR_MASK: begin
               next_s.mask = regReq.wdata[brake_slip_pkg::EV_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // pin synchronisers: stage 0 feeds stage 1 only, stage 2 is history
      next_s.encSync = {s.encSync[1], s.encSync[0], encPulse};
      next_s.dirSync = {s.dirSync[1], s.dirSync[0], encDir};
      next_s.revSync = {s.revSync[1], s.revSync[0], revSensor};
      encEdge = s.encSync[1] & ~s.encSync[2];
      revActNow = s.ctrl.revInvert ? s.revSync[1] : ~s.revSync[1];
      revActPrev = s.ctrl.revInvert ? s.revSync[2] : ~s.revSync[2];
      revEvent = revActNow & ~revActPrev;

      // feedback source choice
      fbEvent = s.ctrl.srcRev ? revEvent : encEdge;
      fbDir = s.ctrl.srcRev ? stepDir : s.dirSync[1];

      stepDelta = '0;
      if (stepPulse) begin
         stepDelta = stepDir ? 16'sh0001 : -16'sh0001;
      end
      fbDelta = '0;
      if (fbEvent) begin
         fbDelta = fbDir ? $signed(s.scale) : -$signed(s.scale);
      end

      // deviation is commanded minus measured; frozen at zero when off
      if (s.ctrl.posEn) begin
         next_s.deviation = s.deviation + stepDelta - fbDelta;
      end else begin
         next_s.deviation = '0;
      end

      over = s.ctrl.posEn &&
         (absVal(s.deviation) > {8'h00, s.threshold});

      // one error per excursion; latch drops once no longer above threshold
      if (!over) begin
         next_s.slipLatched = 1'b0;
      end else if (!s.slipLatched) begin
         next_s.slipLatched = 1'b1;
         events[brake_slip_pkg::EV_SLIP] = 1'b1;
         case (s.ctrl.action)
            brake_slip_pkg::ACT_ALARM: begin
               next_s.alarm = 1'b1;
               events[brake_slip_pkg::EV_ALARM] = 1'b1;
            end
            brake_slip_pkg::ACT_CORRECT: begin
               next_s.correctValid = 1'b1;
               next_s.correctSteps = s.deviation;
               // remove the handed-over error, keep this cycle's motion
               next_s.deviation = next_s.deviation - s.deviation;
            end
            default: begin
               // status only, no further action
            end
         endcase
      end

      // millisecond wait timer, prescaler restarts with every load
      timerDone = (s.msLeft == '0);
      if (!timerDone) begin
         if (s.presc == PRESC_LAST) begin
            next_s.presc = '0;
            next_s.msLeft = s.msLeft - 16'h0001;
         end else begin
            next_s.presc = s.presc + 16'h0001;
         end
      end

      // brake sequencer
      case (s.fsm)
         brake_slip_pkg::ST_PWR_OFF: begin
            next_s.motorPower = 1'b0;
            next_s.brakeEngaged = 1'b1;
            next_s.readyInt = 1'b0;
            if (motionRequest) begin
               next_s.motorPower = 1'b1;
               next_s.msLeft = delayFor(s.ctrl.brakeEn,
                  s.delay[brake_slip_pkg::DLY_ON_REL]);
               next_s.presc = '0;
               next_s.fsm = brake_slip_pkg::ST_ON_WAIT;
            end
         end
         brake_slip_pkg::ST_ON_WAIT: begin
            if (timerDone) begin
               next_s.brakeEngaged = 1'b0;
               next_s.msLeft = delayFor(s.ctrl.brakeEn,
                  s.delay[brake_slip_pkg::DLY_REL_RDY]);
               next_s.presc = '0;
               next_s.fsm = brake_slip_pkg::ST_REL_WAIT;
            end
         end
         brake_slip_pkg::ST_REL_WAIT: begin
            // no motion until the release delay has run out
            if (timerDone) begin
               next_s.readyInt = 1'b1;
               events[brake_slip_pkg::EV_READY] = 1'b1;
               next_s.fsm = brake_slip_pkg::ST_READY;
            end
         end
         brake_slip_pkg::ST_READY: begin
            if (motorStopped && !motionRequest) begin
               next_s.msLeft = delayFor(s.ctrl.brakeEn,
                  s.delay[brake_slip_pkg::DLY_STOP_ENG]);
               next_s.presc = '0;
               next_s.fsm = brake_slip_pkg::ST_STOP_WAIT;
            end
         end
         brake_slip_pkg::ST_STOP_WAIT: begin
            // brake still off here, so a new request resumes at once
            if (motionRequest) begin
               next_s.msLeft = '0;
               next_s.fsm = brake_slip_pkg::ST_READY;
            end else if (timerDone) begin
               next_s.brakeEngaged = 1'b1;
               next_s.readyInt = 1'b0;
               events[brake_slip_pkg::EV_ENGAGE] = 1'b1;
               next_s.msLeft = delayFor(s.ctrl.brakeEn,
                  s.delay[brake_slip_pkg::DLY_ENG_OFF]);
               next_s.presc = '0;
               next_s.fsm = brake_slip_pkg::ST_ENG_WAIT;
            end
         end
         brake_slip_pkg::ST_ENG_WAIT: begin
            if (timerDone) begin
               if (s.ctrl.pwrOffEn) begin
                  next_s.motorPower = 1'b0;
                  next_s.fsm = brake_slip_pkg::ST_PWR_OFF;
               end else begin
                  next_s.fsm = brake_slip_pkg::ST_HOLD;
               end
            end
         end
         brake_slip_pkg::ST_HOLD: begin
            // powered and braked; power is already on for the next start
            if (motionRequest) begin
               next_s.msLeft = delayFor(s.ctrl.brakeEn,
                  s.delay[brake_slip_pkg::DLY_ON_REL]);
               next_s.presc = '0;
               next_s.fsm = brake_slip_pkg::ST_ON_WAIT;
            end
         end
         default: begin
            next_s.fsm = brake_slip_pkg::ST_PWR_OFF;
            next_s.motorPower = 1'b0;
            next_s.brakeEngaged = 1'b1;
            next_s.readyInt = 1'b0;
         end
      endcase

      // alarm withholds readiness until software clears it
      next_s.motionReady = next_s.readyInt & ~next_s.alarm;

      // sticky status, read clears, a new event in that cycle survives
      kept = s.status;
      if (regReq.rd && (regReq.addr == brake_slip_pkg::ADDR_STATUS)) begin
         kept = '0;
      end
      next_s.status = kept | events;
      next_s.irq = |(next_s.status & next_s.mask);

      // read data stands in the cycle after the strobe only
      if (regReq.rd) begin
         case (regReq.addr)
            brake_slip_pkg::ADDR_CTRL: begin
               next_s.rdata = s.ctrl;
            end
            brake_slip_pkg::ADDR_DLY_ON_REL: begin
               next_s.rdata = s.delay[brake_slip_pkg::DLY_ON_REL];
            end
            brake_slip_pkg::ADDR_DLY_REL_RDY: begin
               next_s.rdata = s.delay[brake_slip_pkg::DLY_REL_RDY];
            end
            brake_slip_pkg::ADDR_DLY_STOP_ENG: begin
               next_s.rdata = s.delay[brake_slip_pkg::DLY_STOP_ENG];
            end
            brake_slip_pkg::ADDR_DLY_ENG_OFF: begin
               next_s.rdata = s.delay[brake_slip_pkg::DLY_ENG_OFF];
            end
            brake_slip_pkg::ADDR_THRESHOLD: begin
               next_s.rdata = {8'h00, s.threshold};
            end
            brake_slip_pkg::ADDR_FB_SCALE: begin
               next_s.rdata = s.scale;
            end
            brake_slip_pkg::ADDR_STATUS: begin
               next_s.rdata = {12'h000, s.status};
            end
            brake_slip_pkg::ADDR_MASK: begin
               next_s.rdata = {12'h000, s.mask};
            end
            brake_slip_pkg::ADDR_STATE: begin
               next_s.rdata = {8'h00, s.slipLatched, s.alarm,
                  s.motionReady, s.brakeEngaged, s.motorPower, s.fsm};
            end
            brake_slip_pkg::ADDR_DEVIATION: begin
               next_s.rdata = s.deviation;
            end
            default: begin
               next_s.rdata = '0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         s <= resetState();
      end else begin
         s <= next_s;
      end
   end

   assign regRdata = s.rdata;
   assign motorPower = s.motorPower;
   assign brakeEngaged = s.brakeEngaged;
   assign motionReady = s.motionReady;
   assign alarm = s.alarm;
   assign correctValid = s.correctValid;
   assign correctSteps = s.correctSteps;
   assign irq = s.irq;

endmodule

`default_nettype wire

// ---- test/motor_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module motor_model (
   input wire logic ref_clk, // system clock
   input wire logic stepPulse, // commanded step
   input wire logic stepDir, // commanded direction
   input wire logic echoEnc, // low: steps are lost
   input wire logic revHi, // sensor active level
   input wire logic revFire, // start one revolution mark
   output logic encPulse, // encoder count
   output logic encDir, // encoder direction
   output logic revSensor // revolution sensor
);
   logic [1:0] encCnt = 2'h0;
   logic [4:0] revCnt = 5'h0;
   logic dirQ = 1'b1;
   always @(posedge ref_clk) begin
      if (stepPulse && echoEnc) begin
         encCnt <= 2'h2;
         dirQ <= stepDir;
      end else if (encCnt != 2'h0) begin
         encCnt <= encCnt - 2'h1;
      end
      if (revFire) begin
         revCnt <= 5'h14;
      end else if (revCnt != 5'h0) begin
         revCnt <= revCnt - 5'h1;
      end
   end
   assign encPulse = (encCnt != 2'h0);
   assign encDir = dirQ;
   // long mark: a wrong polarity would count only at its trailing edge
   assign revSensor = (revCnt != 5'h0) ? revHi : !revHi;
endmodule
`default_nettype wire

// ---- test/brake_slip_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module brake_slip_checker #(
   parameter int MS_CYCLES = brake_slip_pkg::MS_CYCLES_DEF
) (
   input wire logic ref_clk, // system clock
   input wire logic reset, // sync reset
   input wire brake_slip_pkg::reg_req_s regReq, // register request
   input wire logic motorStopped, // motor at rest
   input wire logic [brake_slip_pkg::DATA_W-1:0] regRdata, // read data
   input wire logic motorPower, // supply on
   input wire logic brakeEngaged, // brake holding
   input wire logic motionReady, // motion allowed
   input wire logic alarm, // alarm state
   input wire logic correctValid // correction pulse
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   property p_reset_state;
      $fell(reset) |-> brakeEngaged && !motorPower && !motionReady && !alarm;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("outputs not safe after reset");
   property p_ready_released;
      motionReady |-> !brakeEngaged && motorPower;
   endproperty
   a_ready_released: assert property (p_ready_released)
      else $error("ready while brake held or power off");
   property p_release_powered;
      $fell(brakeEngaged) |-> motorPower && $past(motorPower);
   endproperty
   a_release_powered: assert property (p_release_powered)
      else $error("brake released without prior power");
   property p_off_engaged;
      $fell(motorPower) |-> brakeEngaged && $past(brakeEngaged);
   endproperty
   a_off_engaged: assert property (p_off_engaged)
      else $error("power removed before brake engaged");
   property p_engage_stopped;
      $rose(brakeEngaged) |-> $past(motorStopped) && !motionReady;
   endproperty
   a_engage_stopped: assert property (p_engage_stopped)
      else $error("brake engaged without stop");
   property p_unpowered_braked;
      !motorPower |-> brakeEngaged;
   endproperty
   a_unpowered_braked: assert property (p_unpowered_braked)
      else $error("power off with brake released");
   property p_alarm_blocks;
      alarm |-> !motionReady;
   endproperty
   a_alarm_blocks: assert property (p_alarm_blocks)
      else $error("ready during alarm");
   property p_correct_pulse;
      correctValid |=> !correctValid;
   endproperty
   a_correct_pulse: assert property (p_correct_pulse)
      else $error("correction request longer than one cycle");
   property p_rdata_idle;
      !$past(regReq.rd) |-> regRdata == '0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside read answer cycle");
   c_correct: cover property (correctValid);
   c_alarm: cover property ($rose(alarm));
   c_off: cover property ($fell(motorPower));
endmodule
bind brake_slip_monitor brake_slip_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
   .ref_clk(ref_clk), .reset(reset), .regReq(regReq),
   .motorStopped(motorStopped), .regRdata(regRdata),
   .motorPower(motorPower), .brakeEngaged(brakeEngaged),
   .motionReady(motionReady), .alarm(alarm), .correctValid(correctValid));
`default_nettype wire

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int MSC = 4;
   localparam int D[4] = '{2, 3, 1, 2};
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   brake_slip_pkg::reg_req_s regReq = '0;
   logic motionRequest = 1'b0, motorStopped = 1'b0, stepPulse = 1'b0;
   logic stepDir = 1'b1;
   logic echoEnc = 1'b0, revHi = 1'b0, revFire = 1'b0;
   logic encPulse, encDir, revSensor, motorPower, brakeEngaged;
   logic motionReady, alarm, correctValid, irq;
   logic [15:0] regRdata, correctSteps;
   int err_count = 0, comparisons = 0, cvCount = 0;
   always #10 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (correctValid === 1'b1) cvCount <= cvCount + 1;
   brake_slip_monitor #(.MS_CYCLES(MSC)) dut (.ref_clk(ref_clk),
      .reset(reset), .regReq(regReq), .motionRequest(motionRequest),
      .motorStopped(motorStopped), .stepPulse(stepPulse), .stepDir(stepDir),
      .encPulse(encPulse), .encDir(encDir), .revSensor(revSensor),
      .regRdata(regRdata), .motorPower(motorPower),
      .brakeEngaged(brakeEngaged), .motionReady(motionReady), .alarm(alarm),
      .correctValid(correctValid), .correctSteps(correctSteps), .irq(irq));
   motor_model far (.ref_clk(ref_clk), .stepPulse(stepPulse),
      .stepDir(stepDir), .echoEnc(echoEnc), .revHi(revHi), .revFire(revFire),
      .encPulse(encPulse), .encDir(encDir), .revSensor(revSensor));
   task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task stop_test();
      $display("checks %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      regReq.wr <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      regReq <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      regReq.rd <= 1'b0;
      #1 d = regRdata;
   endtask
   // counts edges until the chosen output reaches v; bounded against hangs
   task wt(input int s, input logic v, output int n);
      logic x;
      n = 0;
      x = ~v;
      while (x !== v && n < 2000) begin
         @(posedge ref_clk);
         n++;
         #1;
         case (s)
            0: x = motorPower;
            1: x = brakeEngaged;
            2: x = motionReady;
            3: x = alarm;
            default: x = correctValid;
         endcase
      end
   endtask
   task stp(input int k);
      repeat (k) begin
         repeat (6) @(posedge ref_clk);
         stepPulse <= 1'b1;
         @(posedge ref_clk);
         stepPulse <= 1'b0;
      end
   endtask
   function automatic logic [15:0] dly(input int i, input logic en);
      return en ? 16'(D[i] * MSC + 1) : 16'h1;
   endfunction
   task rst_test();
      logic [15:0] d;
      if ($time > 0) @(posedge ref_clk);
      reset <= 1'b1;
      motionRequest <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      #1 chk("brake", brakeEngaged, 16'h1);
      chk("power", motorPower, 16'h0);
      chk("ready", motionReady, 16'h0);
      rd(brake_slip_pkg::ADDR_CTRL, d);
      chk("ctrl", d, brake_slip_pkg::CTRL_RESET);
      rd(brake_slip_pkg::ADDR_FB_SCALE, d);
      chk("scale", d, brake_slip_pkg::SCALE_RESET);
      rd(4'hb, d);
      chk("unmapped", d, 16'h0);
      rd(brake_slip_pkg::ADDR_STATE, d);
      chk("state", d, 16'h0010);
      wr(brake_slip_pkg::ADDR_DLY_ENG_OFF, 16'hffff);
      rd(brake_slip_pkg::ADDR_DLY_ENG_OFF, d);
      chk("delay max", d, 16'hffff);
      $display("test reset done");
   endtask
   task seq(input logic en, input logic off);
      int n;
      wr(brake_slip_pkg::ADDR_CTRL, {14'h0, off, en});
      @(posedge ref_clk);
      motorStopped <= 1'b0;
      motionRequest <= 1'b1;
      wt(0, 1'b1, n);
      chk("power on", 16'(n), 16'h1);
      wt(1, 1'b0, n);
      chk("release", 16'(n), dly(0, en));
      wt(2, 1'b1, n);
      chk("ready", 16'(n), dly(1, en));
      @(posedge ref_clk);
      motionRequest <= 1'b0;
      motorStopped <= 1'b1;
      wt(1, 1'b1, n);
      chk("engage", 16'(n), dly(2, en) + 16'h1);
      chk("not ready", motionReady, 16'h0);
      if (off) begin
         wt(0, 1'b0, n);
         chk("power off", 16'(n), dly(3, en));
      end else begin
         repeat (D[3] * MSC + 4) @(posedge ref_clk);
         #1 chk("held power", motorPower, 16'h1);
         @(posedge ref_clk);
         motorStopped <= 1'b0;
         motionRequest <= 1'b1;
         wt(1, 1'b0, n);
         chk("re-release", 16'(n), dly(0, en) + 16'h1);
      end
      $display("test brake sequence done");
   endtask
   task cfg(input brake_slip_pkg::err_action_e a, input logic s, v);
      brake_slip_pkg::ctrl_s c;
      logic [15:0] d;
      c = '0;
      c.posEn = 1'b1;
      c.srcRev = s;
      c.action = a;
      c.revInvert = v;
      wr(brake_slip_pkg::ADDR_CTRL, 16'h0);
      wr(brake_slip_pkg::ADDR_CTRL, c);
      rd(brake_slip_pkg::ADDR_STATUS, d);
   endtask
   task slip(input brake_slip_pkg::err_action_e a);
      logic [15:0] d;
      int n, c0;
      logic al, co;
      al = (a == brake_slip_pkg::ACT_ALARM);
      co = (a == brake_slip_pkg::ACT_CORRECT);
      wr(brake_slip_pkg::ADDR_THRESHOLD, 16'h2);
      cfg(a, 1'b0, 1'b0);
      c0 = cvCount;
      stp(2);
      rd(brake_slip_pkg::ADDR_STATUS, d);
      chk("at threshold", d, 16'h0);
      stp(1);
      if (al) begin
         wt(3, 1'b1, n);
         chk("alarm", 16'(n), 16'h1);
         chk("irq masked", irq, 16'h0);
         wr(brake_slip_pkg::ADDR_MASK, 16'h9);
         repeat (2) @(posedge ref_clk);
         #1 chk("irq", irq, 16'h1);
      end else if (co) begin
         wt(4, 1'b1, n);
         chk("correct", 16'(n), 16'h1);
         chk("steps", correctSteps, 16'h3);
      end else begin
         repeat (4) @(posedge ref_clk);
         #1 chk("no alarm", alarm, 16'h0);
         chk("no correct", 16'(cvCount - c0), 16'h0);
      end
      rd(brake_slip_pkg::ADDR_STATUS, d);
      chk("status", d, al ? 16'h9 : 16'h1);
      if (al) begin
         repeat (2) @(posedge ref_clk);
         #1 chk("irq cleared", irq, 16'h0);
         wr(brake_slip_pkg::ADDR_CTRL, 16'h0084);
         @(posedge ref_clk);
         #1 chk("alarm cleared", alarm, 16'h0);
         wr(brake_slip_pkg::ADDR_MASK, 16'h0);
      end
      rd(brake_slip_pkg::ADDR_DEVIATION, d);
      chk("deviation", d, co ? 16'h0 : 16'h3);
      $display("test slip action done");
   endtask
   task posoff();
      logic [15:0] d;
      wr(brake_slip_pkg::ADDR_CTRL, 16'h0);
      rd(brake_slip_pkg::ADDR_STATUS, d);
      stp(3);
      repeat (4) @(posedge ref_clk);
      rd(brake_slip_pkg::ADDR_STATUS, d);
      chk("off status", d, 16'h0);
      rd(brake_slip_pkg::ADDR_DEVIATION, d);
      chk("off deviation", d, 16'h0);
      $display("test monitor off done");
   endtask
   task rev(input logic v);
      logic [15:0] d;
      @(posedge ref_clk);
      revHi <= v;
      echoEnc <= 1'b1;
      wr(brake_slip_pkg::ADDR_FB_SCALE, 16'h1);
      wr(brake_slip_pkg::ADDR_THRESHOLD, 16'hff);
      rd(brake_slip_pkg::ADDR_THRESHOLD, d);
      chk("threshold", d, 16'h00ff);
      cfg(brake_slip_pkg::ACT_IGNORE, 1'b0, v);
      stp(4);
      repeat (6) @(posedge ref_clk);
      rd(brake_slip_pkg::ADDR_DEVIATION, d);
      chk("encoder fed", d, 16'h0);
      wr(brake_slip_pkg::ADDR_FB_SCALE, 16'h4);
      cfg(brake_slip_pkg::ACT_IGNORE, 1'b1, v);
      stp(4);
      repeat (6) @(posedge ref_clk);
      rd(brake_slip_pkg::ADDR_DEVIATION, d);
      chk("encoder unused", d, 16'h4);
      @(posedge ref_clk);
      revFire <= 1'b1;
      @(posedge ref_clk);
      revFire <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd(brake_slip_pkg::ADDR_DEVIATION, d);
      chk("revolution", d, 16'h0);
      repeat (24) @(posedge ref_clk);
      $display("test revolution sensor done");
   endtask
   initial begin
      #1_000_000;
      err_count++;
      stop_test();
   end
   initial begin
      rst_test();
      for (int i = 0; i < 4; i++) begin
         wr(4'(brake_slip_pkg::ADDR_DLY_ON_REL + i), 16'(D[i]));
      end
      seq(1'b0, 1'b1);
      seq(1'b1, 1'b1);
      seq(1'b1, 1'b0);
      rst_test();
      slip(brake_slip_pkg::ACT_CORRECT);
      slip(brake_slip_pkg::ACT_ALARM);
      slip(brake_slip_pkg::ACT_IGNORE);
      slip(brake_slip_pkg::err_action_e'(2'h3));
      posoff();
      rev(1'b0);
      rev(1'b1);
      stop_test();
   end
endmodule
`default_nettype wire
